// File: hw/spp_pkg.sv
// Constants and carrier types for the signal power protect block.
// Assumes a byte-wide register port with a 12-bit address.
package spp_pkg;
    localparam logic [11:0] ADDR_KEY_I_LOW = 12'h051;
    localparam logic [11:0] ADDR_KEY_I_HIGH = 12'h052;
    localparam logic [11:0] ADDR_KEY_Q_LOW = 12'h053;
    localparam logic [11:0] ADDR_KEY_Q_HIGH = 12'h054;
    localparam logic [11:0] ADDR_THRESH_LOW = 12'h060;
    localparam logic [11:0] ADDR_THRESH_HIGH = 12'h061;
    localparam logic [11:0] ADDR_AVG_CTRL = 12'h062;
    localparam logic [11:0] ADDR_RESULT_LOW = 12'h063;
    localparam logic [11:0] ADDR_RESULT_HIGH = 12'h064;
    localparam logic [11:0] ADDR_GAINOFF_A = 12'h065;
    localparam logic [11:0] ADDR_GAINOFF_B = 12'h066;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int CALC_ENABLE_BIT = 7;
    localparam logic [3:0] WINDOW_MAX = 4'hA;
    localparam int WINDOW_BASE_LOG2 = 9;
    localparam int SAMPLE_MSBS = 6;
    localparam int GA_UKC_BIT = 7;
    localparam int GA_LATBUF_BIT = 1;
    localparam int GA_LANEFIFO_BIT = 0;
    localparam int GB_MISMATCH_BIT = 7;
    localparam int GB_SYNC_BIT = 6;
    localparam int GB_FRAME_BIT = 5;
    localparam int GB_CHECKSUM_BIT = 4;
    localparam int GB_ALIGN_BIT = 3;
    localparam int GB_DESKEW_BIT = 2;
    localparam int GB_DISPARITY_BIT = 1;
    localparam int GB_TABLE_BIT = 0;
    localparam logic [1:0] ALIGN_ON_KEY = 2'h2;
    localparam int ACC_W = 33;

    typedef struct packed {
        logic valid;
        logic [15:0] i;
        logic [15:0] q;
    } spp_sample_type;

    // Error sources from the link receiver, one level each
    typedef struct packed {
        logic unexpected_control_char;
        logic latency_buffer_error;
        logic lane_fifo_error;
        logic config_mismatch;
        logic code_group_sync_fail;
        logic frame_sync_fail;
        logic checksum_fail;
        logic lane_align_fail;
        logic deskew_fail;
        logic disparity_count;
        logic not_in_table_count;
    } spp_errors_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } spp_regreq_type;
endpackage

// File: hw/spp_top.sv
// Signal power protect: key registers, power detector, gain-off logic.
// Assumes samples, errors and register requests are on CORE_CLK.
`timescale 1ns/10ps
module spp_top
    import spp_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire spp_regreq_type REG_REQ,
    output logic [7:0] REG_RDATA,
    input wire spp_sample_type SAMPLE_IN,
    input wire spp_errors_type ERRORS,
    input wire logic [1:0] ALIGN_SELECT,
    output spp_sample_type SAMPLE_OUT,
    output logic KEY_MATCH,
    output logic POWER_PROTECT,
    output logic GAIN_OFF
);
    // ****************************************************************
    // Register bank
    // ****************************************************************
    logic [15:0] key_i_reg;
    logic [15:0] key_q_reg;
    logic [12:0] limit_reg;
    logic calc_en_reg;
    logic [3:0] window_reg;
    logic [7:0] gain_a_reg;
    logic [7:0] gain_b_reg;
    logic [12:0] result_reg;
    logic protect_reg;

    function automatic logic hit(input logic [11:0] a);
        hit = REG_REQ.wr && (REG_REQ.addr == a);
    endfunction

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            key_i_reg <= {RESET_BYTE, RESET_BYTE};
            key_q_reg <= {RESET_BYTE, RESET_BYTE};
        end else begin
            if (hit(ADDR_KEY_I_LOW)) key_i_reg[7:0] <= REG_REQ.wdata;
            if (hit(ADDR_KEY_I_HIGH)) key_i_reg[15:8] <= REG_REQ.wdata;
            if (hit(ADDR_KEY_Q_LOW)) key_q_reg[7:0] <= REG_REQ.wdata;
            if (hit(ADDR_KEY_Q_HIGH)) key_q_reg[15:8] <= REG_REQ.wdata;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            limit_reg <= 13'h0000;
            calc_en_reg <= 1'b0;
            window_reg <= 4'h0;
        end else begin
            if (hit(ADDR_THRESH_LOW)) limit_reg[7:0] <= REG_REQ.wdata;
            if (hit(ADDR_THRESH_HIGH)) limit_reg[12:8] <= REG_REQ.wdata[4:0];
            if (hit(ADDR_AVG_CTRL)) begin
                calc_en_reg <= REG_REQ.wdata[CALC_ENABLE_BIT];
                // Saturate out-of-range settings at the maximum
                window_reg <= (REG_REQ.wdata[3:0] > WINDOW_MAX) ?
                    WINDOW_MAX : REG_REQ.wdata[3:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            gain_a_reg <= RESET_BYTE;
            gain_b_reg <= RESET_BYTE;
        end else begin
            if (hit(ADDR_GAINOFF_A)) gain_a_reg <= REG_REQ.wdata;
            if (hit(ADDR_GAINOFF_B)) gain_b_reg <= REG_REQ.wdata;
        end
    end

    // Read data registered: answer one cycle after rd
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            REG_RDATA <= RESET_BYTE;
        end else if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                ADDR_KEY_I_LOW: REG_RDATA <= key_i_reg[7:0];
                ADDR_KEY_I_HIGH: REG_RDATA <= key_i_reg[15:8];
                ADDR_KEY_Q_LOW: REG_RDATA <= key_q_reg[7:0];
                ADDR_KEY_Q_HIGH: REG_RDATA <= key_q_reg[15:8];
                ADDR_THRESH_LOW: REG_RDATA <= limit_reg[7:0];
                ADDR_THRESH_HIGH: REG_RDATA <= {3'h0, limit_reg[12:8]};
                ADDR_AVG_CTRL: REG_RDATA <= {calc_en_reg, 3'h0, window_reg};
                ADDR_RESULT_LOW: REG_RDATA <= result_reg[7:0];
                ADDR_RESULT_HIGH: REG_RDATA <= {3'h0, result_reg[12:8]};
                ADDR_GAINOFF_A: REG_RDATA <= gain_a_reg;
                ADDR_GAINOFF_B: REG_RDATA <= gain_b_reg;
                default: REG_RDATA <= RESET_BYTE;
            endcase
        end
    end

    // ****************************************************************
    // Data key match
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            KEY_MATCH <= 1'b0;
        end else begin
            KEY_MATCH <= (ALIGN_SELECT == ALIGN_ON_KEY) && SAMPLE_IN.valid
                && (SAMPLE_IN.i == key_i_reg)
                && (SAMPLE_IN.q == key_q_reg);
        end
    end

    // ****************************************************************
    // Power detector
    // ****************************************************************
    logic [5:0] i_top;
    logic [5:0] q_top;
    logic [11:0] i_ext;
    logic [11:0] q_ext;
    logic [11:0] i_sq;
    logic [11:0] q_sq;
    logic [12:0] pwr;
    logic [ACC_W-1:0] acc_reg;
    logic [19:0] count_reg;
    logic [19:0] window_len;
    logic last_sample;

    // Signed top six bits; square magnitude fits 12 bits
    assign i_top = SAMPLE_IN.i[15:16-SAMPLE_MSBS];
    assign q_top = SAMPLE_IN.q[15:16-SAMPLE_MSBS];
    assign i_ext = {{(12-SAMPLE_MSBS){i_top[SAMPLE_MSBS-1]}}, i_top};
    assign q_ext = {{(12-SAMPLE_MSBS){q_top[SAMPLE_MSBS-1]}}, q_top};
    assign i_sq = 12'($signed(i_ext) * $signed(i_ext));
    assign q_sq = 12'($signed(q_ext) * $signed(q_ext));
    assign pwr = {1'b0, i_sq} + {1'b0, q_sq};
    assign window_len = 20'(1) << (WINDOW_BASE_LOG2 + 32'(window_reg));
    // Also ends a window cut short by a smaller setting
    assign last_sample = (count_reg >= window_len - 20'h00001);

    // Block average over the window, result updated at window end
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            acc_reg <= '0;
            count_reg <= 20'h00000;
        end else if (!calc_en_reg) begin
            acc_reg <= '0;
            count_reg <= 20'h00000;
        end else if (SAMPLE_IN.valid) begin
            if (last_sample) begin
                acc_reg <= '0;
                count_reg <= 20'h00000;
            end else begin
                acc_reg <= acc_reg + ACC_W'(pwr);
                count_reg <= count_reg + 20'h00001;
            end
        end
    end

    logic [ACC_W-1:0] acc_final;
    logic [12:0] avg_now;
    assign acc_final = acc_reg + ACC_W'(pwr);
    assign avg_now = 13'(acc_final >> (WINDOW_BASE_LOG2 + 32'(window_reg)));

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            result_reg <= 13'h0000;
            protect_reg <= 1'b0;
        end else if (calc_en_reg && SAMPLE_IN.valid && last_sample) begin
            // Result freezes once the limit has been exceeded
            if (!protect_reg) result_reg <= avg_now;
            if (avg_now > limit_reg) protect_reg <= 1'b1;
        end else if (!calc_en_reg) begin
            protect_reg <= 1'b0;
        end
    end
    assign POWER_PROTECT = protect_reg;

    // ****************************************************************
    // Gain off
    // ****************************************************************
    logic gain_off_now;
    always_comb begin
        gain_off_now =
            (gain_a_reg[GA_UKC_BIT] && ERRORS.unexpected_control_char)
            || (gain_a_reg[GA_LATBUF_BIT] && ERRORS.latency_buffer_error)
            || (gain_a_reg[GA_LANEFIFO_BIT] && ERRORS.lane_fifo_error)
            || (gain_b_reg[GB_MISMATCH_BIT] && ERRORS.config_mismatch)
            || (gain_b_reg[GB_SYNC_BIT] && ERRORS.code_group_sync_fail)
            || (gain_b_reg[GB_FRAME_BIT] && ERRORS.frame_sync_fail)
            || (gain_b_reg[GB_CHECKSUM_BIT] && ERRORS.checksum_fail)
            || (gain_b_reg[GB_ALIGN_BIT] && ERRORS.lane_align_fail)
            || (gain_b_reg[GB_DESKEW_BIT] && ERRORS.deskew_fail)
            || (gain_b_reg[GB_DISPARITY_BIT] && ERRORS.disparity_count)
            || (gain_b_reg[GB_TABLE_BIT] && ERRORS.not_in_table_count);
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            GAIN_OFF <= 1'b0;
            SAMPLE_OUT <= '0;
        end else begin
            GAIN_OFF <= gain_off_now;
            SAMPLE_OUT.valid <= SAMPLE_IN.valid;
            SAMPLE_OUT.i <= gain_off_now ? 16'h0000 : SAMPLE_IN.i;
            SAMPLE_OUT.q <= gain_off_now ? 16'h0000 : SAMPLE_IN.q;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_KEY_I_WRITE: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        hit(ADDR_KEY_I_LOW) |=> key_i_reg[7:0] == $past(REG_REQ.wdata))
        else $error("I key low byte not written");
    AST_KEY_I_HIGH: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        hit(ADDR_KEY_I_HIGH) |=> key_i_reg[15:8] == $past(REG_REQ.wdata))
        else $error("I key high byte not written");
    AST_KEY_Q_LOW: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        hit(ADDR_KEY_Q_LOW) |=> key_q_reg[7:0] == $past(REG_REQ.wdata))
        else $error("Q key low byte not written");
    AST_KEY_Q_WRITE: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        hit(ADDR_KEY_Q_HIGH) |=> key_q_reg[15:8] == $past(REG_REQ.wdata))
        else $error("Q key high byte not written");
    AST_MATCH_GATED: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        ALIGN_SELECT != ALIGN_ON_KEY |=> !KEY_MATCH)
        else $error("Key match outside key mode");
    AST_PROTECT_CAUSE: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        $rose(protect_reg) |-> $past(avg_now) > $past(limit_reg))
        else $error("Protect raised without crossing");
    AST_LIMIT_LOW: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        hit(ADDR_THRESH_LOW) |=> limit_reg[7:0] == $past(REG_REQ.wdata))
        else $error("Limit low byte not written");
    AST_LIMIT_HIGH: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        hit(ADDR_THRESH_HIGH)
        |=> limit_reg[12:8] == $past(REG_REQ.wdata[4:0]))
        else $error("Limit high bits not written");
    AST_PROTECT_STICKY: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        protect_reg && calc_en_reg |=> protect_reg)
        else $error("Protect dropped while enabled");
    AST_IDLE_WHEN_OFF: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        !calc_en_reg ##1 !calc_en_reg |-> count_reg == 20'h00000)
        else $error("Counter runs while disabled");
    AST_CALC_EN_WRITE: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        hit(ADDR_AVG_CTRL)
        |=> calc_en_reg == $past(REG_REQ.wdata[CALC_ENABLE_BIT]))
        else $error("Enable bit not written");
    AST_PROTECT_CLEAR: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        !calc_en_reg |=> !protect_reg && acc_reg == '0)
        else $error("Detector state kept while disabled");
    AST_WINDOW_RESTART: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        calc_en_reg && SAMPLE_IN.valid && last_sample
        |=> count_reg == 20'h00000)
        else $error("Window did not restart");
    AST_COUNT_BOUND: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        count_reg < window_len && !hit(ADDR_AVG_CTRL)
        |=> count_reg < window_len)
        else $error("Sample count ran past the window");
    AST_WINDOW_SAT: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        window_reg <= WINDOW_MAX)
        else $error("Window setting above maximum");
    AST_RESULT_FROZEN: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        protect_reg && $past(protect_reg) |-> $stable(result_reg))
        else $error("Result moved after protect");
    AST_SQUARE_I: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        SAMPLE_IN.i[15:10] == 6'h20 |-> i_sq == 12'h400)
        else $error("I square of most negative value wrong");
    AST_SQUARE_Q: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        SAMPLE_IN.q[15:10] == 6'h1F |-> q_sq == 12'h3C1)
        else $error("Q square of largest value wrong");
    AST_GAIN_UKC: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_a_reg[GA_UKC_BIT] && ERRORS.unexpected_control_char |=> GAIN_OFF)
        else $error("Control character error did not cut gain");
    AST_GAIN_LATBUF: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_a_reg[GA_LATBUF_BIT] && ERRORS.latency_buffer_error |=> GAIN_OFF)
        else $error("Latency buffer error did not cut gain");
    AST_LANE_FIFO: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_a_reg[GA_LANEFIFO_BIT] && ERRORS.lane_fifo_error |=> GAIN_OFF)
        else $error("Lane FIFO error did not cut gain");
    AST_GAIN_MISMATCH: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_b_reg[GB_MISMATCH_BIT] && ERRORS.config_mismatch |=> GAIN_OFF)
        else $error("Configuration mismatch did not cut gain");
    AST_GAIN_SYNC: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_b_reg[GB_SYNC_BIT] && ERRORS.code_group_sync_fail |=> GAIN_OFF)
        else $error("Code group sync failure did not cut gain");
    AST_GAIN_FRAME: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_b_reg[GB_FRAME_BIT] && ERRORS.frame_sync_fail |=> GAIN_OFF)
        else $error("Frame sync failure did not cut gain");
    AST_GAIN_CHECKSUM: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_b_reg[GB_CHECKSUM_BIT] && ERRORS.checksum_fail |=> GAIN_OFF)
        else $error("Checksum failure did not cut gain");
    AST_GAIN_ALIGN: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_b_reg[GB_ALIGN_BIT] && ERRORS.lane_align_fail |=> GAIN_OFF)
        else $error("Lane alignment failure did not cut gain");
    AST_GAIN_DESKEW: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_b_reg[GB_DESKEW_BIT] && ERRORS.deskew_fail |=> GAIN_OFF)
        else $error("Deskew failure did not cut gain");
    AST_GAIN_DISPARITY: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_b_reg[GB_DISPARITY_BIT] && ERRORS.disparity_count |=> GAIN_OFF)
        else $error("Disparity count did not cut gain");
    AST_GAIN_TABLE: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_b_reg[GB_TABLE_BIT] && ERRORS.not_in_table_count |=> GAIN_OFF)
        else $error("Not-in-table count did not cut gain");
    AST_GAIN_ZERO: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        GAIN_OFF |-> SAMPLE_OUT.i == 16'h0000 && SAMPLE_OUT.q == 16'h0000)
        else $error("Samples pass while gain off");
    AST_NO_ENABLE: assert property (
        @(posedge CORE_CLK) disable iff (!NRST)
        gain_a_reg == 8'h00 && gain_b_reg == 8'h00 |=> !GAIN_OFF)
        else $error("Gain off with no source enabled");
endmodule // spp_top

// File: verification/spp_src.sv
// Upstream sample source model for the power protect block.
// Assumes start is a one-cycle pulse on the shared clock.
`timescale 1ns/10ps
module spp_src
    import spp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic slow,
    input wire logic [15:0] cnt,
    input wire logic [15:0] si,
    input wire logic [15:0] sq,
    output spp_sample_type smp,
    output logic busy
);
    logic [15:0] left_reg;
    logic gap_reg;
    assign busy = (left_reg != 16'h0000);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            left_reg <= 16'h0000;
            gap_reg <= 1'b0;
            smp <= '0;
        end else if (start) begin
            left_reg <= cnt;
            gap_reg <= 1'b0;
            smp.valid <= 1'b0;
        end else if (busy && !(slow && gap_reg)) begin
            smp <= {1'b1, si, sq};
            left_reg <= left_reg - 16'h0001;
            gap_reg <= 1'b1;
        end else begin
            // Idle lines do not keep the last pair
            smp.valid <= 1'b0;
            smp.i <= ~smp.i;
            smp.q <= ~smp.q;
            gap_reg <= 1'b0;
        end
    end
endmodule // spp_src

// File: verification/tb_top.sv
// Self-checking bench for spp_top with the upstream sample source.
// Assumes one 100 MHz clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module tb_top
    import spp_pkg::*;
();
    typedef struct {
        logic [11:0] a;
        logic [7:0] w;
        logic [7:0] e;
    } spp_row_type;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    spp_regreq_type req = '0;
    spp_errors_type errs = '0;
    logic [1:0] align = 2'h0;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic [15:0] cnt = 16'h0000;
    logic [15:0] si = 16'h0000;
    logic [15:0] sq = 16'h0000;
    logic [7:0] rdata;
    spp_sample_type smp_in;
    spp_sample_type smp_out;
    logic key_match;
    logic protect;
    logic gain_off;
    logic busy;
    logic [10:0] en;
    int n_fail = 0;
    int num_checks = 0;
    spp_row_type rows [12] = '{
        '{ADDR_KEY_I_LOW, 8'hA5, 8'hA5}, '{ADDR_KEY_I_HIGH, 8'h5A, 8'h5A},
        '{ADDR_KEY_Q_LOW, 8'h3C, 8'h3C}, '{ADDR_KEY_Q_HIGH, 8'hC3, 8'hC3},
        '{ADDR_THRESH_LOW, 8'hFF, 8'hFF}, '{ADDR_THRESH_HIGH, 8'hFF, 8'h1F},
        '{ADDR_AVG_CTRL, 8'h7F, 8'h0A}, '{ADDR_RESULT_LOW, 8'hFF, 8'h00},
        '{ADDR_RESULT_HIGH, 8'hFF, 8'h00}, '{ADDR_GAINOFF_A, 8'hFF, 8'hFF},
        '{ADDR_GAINOFF_B, 8'hFF, 8'hFF}, '{12'h070, 8'hFF, 8'h00}};
    logic [1:0] kal [4] = '{ALIGN_ON_KEY, 2'h1, ALIGN_ON_KEY, 2'h0};
    logic [15:0] kq [4] = '{16'hC33C, 16'hC33C, 16'hC33D, 16'hC33C};
    logic kex [4] = '{1'b1, 1'b0, 1'b0, 1'b0};

    spp_top dut (
        .CORE_CLK(clk),
        .NRST(nrst),
        .REG_REQ(req),
        .REG_RDATA(rdata),
        .SAMPLE_IN(smp_in),
        .ERRORS(errs),
        .ALIGN_SELECT(align),
        .SAMPLE_OUT(smp_out),
        .KEY_MATCH(key_match),
        .POWER_PROTECT(protect),
        .GAIN_OFF(gain_off)
    );
    spp_src src (
        .clk(clk),
        .nrst(nrst),
        .start(start),
        .slow(slow),
        .cnt(cnt),
        .si(si),
        .sq(sq),
        .smp(smp_in),
        .busy(busy)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        #1;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic run(input logic s, input logic [15:0] n,
                       input logic [15:0] i, input logic [15:0] q);
        @(posedge clk);
        start <= 1'b1;
        slow <= s;
        cnt <= n;
        si <= i;
        sq <= q;
        @(posedge clk);
        start <= 1'b0;
    endtask

    task automatic wait_src();
        int k;
        k = 0;
        repeat (2) @(posedge clk);
        while (busy && k < 3000) begin
            @(posedge clk);
            k++;
        end
        if (busy) begin
            n_fail++;
            give_verdict();
        end
        settle();
    endtask

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[n]) begin
            acc(1'b0, rows[n].a, 8'h00);
            check(rdata, RESET_BYTE);
            acc(1'b1, rows[n].a, rows[n].w);
            acc(1'b0, rows[n].a, 8'h00);
            check(rdata, rows[n].e);
        end
        for (int n = 0; n < 4; n++) begin
            @(posedge clk);
            align <= kal[n];
            run(1'b0, 16'h0008, 16'h5AA5, kq[n]);
            repeat (4) @(posedge clk);
            #1;
            check(key_match, kex[n]);
            check(smp_out, {1'b1, 16'h5AA5, kq[n]});
            wait_src();
        end
        // Top six bits give 31 and -32: power 1985 per pair
        acc(1'b1, ADDR_AVG_CTRL, 8'h80);
        run(1'b0, 16'h0200, 16'h7FFF, 16'h8000);
        wait_src();
        check(protect, 1'b0);
        acc(1'b0, ADDR_RESULT_LOW, 8'h00);
        check(rdata, 8'hC1);
        acc(1'b0, ADDR_RESULT_HIGH, 8'h00);
        check(rdata, 8'h07);
        acc(1'b1, ADDR_THRESH_LOW, 8'hC0);
        acc(1'b1, ADDR_THRESH_HIGH, 8'h07);
        acc(1'b1, ADDR_AVG_CTRL, 8'h00);
        acc(1'b1, ADDR_AVG_CTRL, 8'h81);
        run(1'b1, 16'h0200, 16'h7FFF, 16'h8000);
        wait_src();
        check(protect, 1'b0);
        run(1'b1, 16'h0200, 16'h7FFF, 16'h8000);
        wait_src();
        check(protect, 1'b1);
        acc(1'b1, ADDR_AVG_CTRL, 8'h00);
        settle();
        check(protect, 1'b0);
        run(1'b0, 16'h0180, 16'h1234, 16'h4321);
        for (int k = 0; k < 11; k++) begin
            en = 11'h001 << k;
            acc(1'b1, ADDR_GAINOFF_A, {en[10], 5'h00, en[9:8]});
            acc(1'b1, ADDR_GAINOFF_B, en[7:0]);
            @(posedge clk);
            errs <= ~en;
            settle();
            check(gain_off, 1'b0);
            @(posedge clk);
            errs <= en;
            settle();
            check(gain_off, 1'b1);
            check({smp_out.i, smp_out.q}, 32'h0);
        end
        @(posedge clk);
        errs <= '0;
        wait_src();
        give_verdict();
    end
endmodule // tb_top
